// ---- rsc_pkg.sv ----
package rsc_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int RSC_ADDR_W = 4;
  localparam int RSC_DATA_W = 16;
  localparam logic [3:0] RSC_CAUSE_IDX = 4'h0;
  localparam logic [3:0] RSC_OSC_CTRL_IDX = 4'h1;
  localparam logic [3:0] RSC_AUX_CTRL_IDX = 4'h2;
  localparam logic [15:0] RSC_READ_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  localparam int RSC_CAUSE_W = 8;
  localparam int RSC_CAUSE_POR_BIT = 0;
  localparam int RSC_CAUSE_BOR_BIT = 1;
  localparam int RSC_CAUSE_EXT_BIT = 2;
  localparam int RSC_CAUSE_SW_BIT = 3;
  localparam int RSC_CAUSE_WDT_BIT = 4;
  localparam int RSC_CAUSE_CFG_BIT = 5;
  localparam int RSC_CAUSE_TRAP_BIT = 6;
  localparam int RSC_CAUSE_ILL_BIT = 7;
  localparam logic [7:0] RSC_CAUSE_POR_VALUE = 8'h03;
  localparam logic [7:0] RSC_CAUSE_CLEAR = 8'h00;

  // ----------------------------------------------------------------
  // oscillator control and configuration word
  // ----------------------------------------------------------------
  localparam int RSC_NEW_OSC_FIELD_LSB = 8;
  localparam int RSC_NEW_OSC_FIELD_MSB = 10;
  localparam int RSC_PTYPE_LSB = 0;
  localparam int RSC_PTYPE_MSB = 1;
  localparam int RSC_CFG_SEL_LSB = 0;
  localparam int RSC_CFG_SEL_MSB = 2;
  localparam int RSC_CFG_PTYPE_LSB = 3;
  localparam int RSC_CFG_PTYPE_MSB = 4;
  localparam logic [7:0] RSC_CFG_ERASED = 8'hFF;

  localparam logic [2:0] RSC_OSC_INTERNAL_RC_DIV_N = 3'h7;
  localparam logic [2:0] RSC_OSC_INTERNAL_RC_DIV16 = 3'h6;
  localparam logic [2:0] RSC_OSC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] RSC_OSC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] RSC_OSC_PRIMARY = 3'h2;
  localparam logic [2:0] RSC_OSC_INTERNAL_RC_DIV_N_PLL = 3'h1;
  localparam logic [2:0] RSC_OSC_INTERNAL_RC = 3'h0;

  localparam logic [1:0] RSC_PTYPE_HS_CRYSTAL = 2'h2;
  localparam logic [1:0] RSC_PTYPE_STD_CRYSTAL = 2'h1;
  localparam logic [1:0] RSC_PTYPE_EXT_CLOCK = 2'h0;

  // ----------------------------------------------------------------
  // auxiliary multiplier
  // ----------------------------------------------------------------
  localparam int RSC_AUX_SRC_BIT = 0;
  localparam int RSC_AUX_EN_BIT = 1;
  localparam logic [4:0] RSC_AUX_MULT_FACTOR = 5'h10;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic brown_out;
    logic ext_clear;
    logic sw_instr;
    logic wdt_timeout;
    logic cfg_mismatch;
    logic trap_conflict;
    logic illegal_opcode;
    logic uninit_wreg;
    logic security;
  } rsc_src_type;

  typedef struct packed {
    logic valid;
    logic is_primary;
    logic pll_en;
    logic div_n;
    logic div16;
    logic low_power;
    logic [1:0] prim_type;
  } rsc_osc_mode_type;

  typedef struct packed {
    logic enable;
    logic src_primary;
    logic [4:0] mult;
  } rsc_aux_type;

endpackage

// ---- rsc_reset_sync.sv ----
`timescale 1ns/10ps
module rsc_reset_sync (
  input wire logic clk, // system clock
  input wire logic async_set, // raw combined reset
  output logic sync_reg // reset, released on clock
);

  logic meta_reg;

  // set acts at once; release needs two clean edges
  always_ff @(posedge clk or posedge async_set) begin
    if (async_set) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= 1'b0;
      sync_reg <= meta_reg;
    end
  end

endmodule

// ---- rsc_src_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// reset source model: one request level at a time
// ------------------------------------------------------------
module rsc_src_model (
  input wire logic fire, // raise the chosen source
  input wire logic [3:0] idx, // source number, 0 is power-on
  output rsc_pkg::rsc_src_type src // request levels
);
  // one-hot keeps each cause flag separately observable
  assign src = fire ? rsc_pkg::rsc_src_type'(10'h200 >> idx) : '0;
endmodule

// ---- rsc_top.sv ----
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - any active source asserts master reset
// RULE_02 - combine eight sources, illegal covers three
// RULE_03 - reset forces some registers, others kept
// RULE_04 - each reset sets its own cause flag
// RULE_05 - power-on clears flags, sets bits one, zero
// RULE_06 - software sets or clears flags anytime
// RULE_07 - flag writes never cause a reset
// RULE_08 - software clears flags after reading them
// RULE_09 - reset loads configured select into new-osc field
// RULE_10 - oscillator select codes decode to modes
// RULE_11 - primary type field picks crystal or clock
// RULE_12 - erased configuration starts internal RC divide-N
// RULE_13 - auxiliary multiplier fixed at sixteen
// RULE_14 - assert asynchronously, release synchronously after all
module rsc_top (
  input wire logic CLK, // system clock
  input wire logic RST, // async reset, high
  input wire rsc_pkg::rsc_src_type RESET_SOURCES, // reset requests
  input wire logic [7:0] OSC_SELECT_CONFIG_WORD, // nonvolatile config
  input wire logic [3:0] ADDR, // register index
  input wire logic [15:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [15:0] RDATA, // read data
  output logic MASTER_SYSTEM_RESET, // combined reset
  output rsc_pkg::rsc_osc_mode_type OSC_MODE, // decoded clock mode
  output rsc_pkg::rsc_aux_type AUX_CLOCK // aux multiplier setup
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] idx);
    reg_hit = (addr == idx);
  endfunction

  function automatic rsc_pkg::rsc_osc_mode_type osc_decode(
    input logic [2:0] sel,
    input logic [1:0] ptype);
    rsc_pkg::rsc_osc_mode_type m;
    m = '0;
    m.valid = 1'b1;
    case (sel)
      rsc_pkg::RSC_OSC_INTERNAL_RC_DIV_N: begin
        m.div_n = 1'b1;
      end
      rsc_pkg::RSC_OSC_INTERNAL_RC_DIV16: begin
        m.div16 = 1'b1;
      end
      rsc_pkg::RSC_OSC_LOW_POWER_RC: begin
        m.low_power = 1'b1;
      end
      rsc_pkg::RSC_OSC_PRIMARY_PLL: begin
        m.is_primary = 1'b1;
        m.pll_en = 1'b1;
      end
      rsc_pkg::RSC_OSC_PRIMARY: begin
        m.is_primary = 1'b1;
      end
      rsc_pkg::RSC_OSC_INTERNAL_RC_DIV_N_PLL: begin
        m.div_n = 1'b1;
        m.pll_en = 1'b1;
      end
      rsc_pkg::RSC_OSC_INTERNAL_RC: begin
        m.valid = 1'b1;
      end
      default: begin
        // unlisted code: no mode bits set and valid cleared
        m.valid = 1'b0;
      end
    endcase
    // type field only matters for a primary source
    if (m.is_primary) begin
      m.prim_type = ptype;
    end
    osc_decode = m;
  endfunction

  // ----------------------------------------------------------------
  // source combining
  // ----------------------------------------------------------------
  logic illegal_any;
  logic any_src;
  logic [7:0] src_vec;
  logic master_rst;

  assign illegal_any = RESET_SOURCES.illegal_opcode |
                       RESET_SOURCES.uninit_wreg |
                       RESET_SOURCES.security; // RULE_02
  assign src_vec = {illegal_any,
                    RESET_SOURCES.trap_conflict,
                    RESET_SOURCES.cfg_mismatch,
                    RESET_SOURCES.wdt_timeout,
                    RESET_SOURCES.sw_instr,
                    RESET_SOURCES.ext_clear,
                    RESET_SOURCES.brown_out,
                    RESET_SOURCES.power_on}; // RULE_02
  // block reset joins the sources so outputs are held from power-up
  assign any_src = (|src_vec) | RST; // RULE_01

  rsc_reset_sync u_sync (
    .clk(CLK),
    .async_set(any_src),
    .sync_reg(master_rst)
  ); // RULE_14

  assign MASTER_SYSTEM_RESET = master_rst;

  // ----------------------------------------------------------------
  // reset cause register
  // ----------------------------------------------------------------
  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic [7:0] cause_base;
  logic cause_wr;

  assign cause_wr = WR & reg_hit(ADDR, rsc_pkg::RSC_CAUSE_IDX); // RULE_07

  // active sources win over a clearing write in the same cycle
  always_comb begin
    cause_base = cause_reg;
    if (cause_wr) begin
      cause_base = WDATA[7:0]; // RULE_06
    end
    if (RESET_SOURCES.power_on) begin
      cause_base = rsc_pkg::RSC_CAUSE_CLEAR; // RULE_05
    end
    cause_next = cause_base | src_vec; // RULE_04
    if (RESET_SOURCES.power_on) begin
      cause_next = cause_next | rsc_pkg::RSC_CAUSE_POR_VALUE; // RULE_05
    end
  end

  // kept across non-power resets, so reset only by the block reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cause_reg <= rsc_pkg::RSC_CAUSE_POR_VALUE; // RULE_05
    end else begin
      cause_reg <= cause_next; // RULE_03
    end
  end

  // ----------------------------------------------------------------
  // oscillator control
  // ----------------------------------------------------------------
  logic [2:0] new_osc_field_reg;
  logic [1:0] ptype_reg;
  logic osc_wr;

  assign osc_wr = WR & reg_hit(ADDR, rsc_pkg::RSC_OSC_CTRL_IDX);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      new_osc_field_reg <= rsc_pkg::RSC_OSC_INTERNAL_RC_DIV_N; // RULE_12
      ptype_reg <= rsc_pkg::RSC_PTYPE_EXT_CLOCK;
    end else if (master_rst) begin
      // config word sampled on the clock, never by the async reset
      new_osc_field_reg <= OSC_SELECT_CONFIG_WORD[rsc_pkg::RSC_CFG_SEL_MSB:
                                         rsc_pkg::RSC_CFG_SEL_LSB]; // RULE_09
      ptype_reg <= OSC_SELECT_CONFIG_WORD[rsc_pkg::RSC_CFG_PTYPE_MSB:
                                          rsc_pkg::RSC_CFG_PTYPE_LSB]; // RULE_03
    end else if (osc_wr) begin
      new_osc_field_reg <= WDATA[rsc_pkg::RSC_NEW_OSC_FIELD_MSB:rsc_pkg::RSC_NEW_OSC_FIELD_LSB];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OSC_MODE <= '0;
    end else begin
      OSC_MODE <= osc_decode(new_osc_field_reg, ptype_reg); // RULE_10 RULE_11
    end
  end

  // ----------------------------------------------------------------
  // auxiliary multiplier
  // ----------------------------------------------------------------
  logic aux_wr;

  assign aux_wr = WR & reg_hit(ADDR, rsc_pkg::RSC_AUX_CTRL_IDX);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AUX_CLOCK <= '0;
    end else if (master_rst) begin
      AUX_CLOCK.enable <= 1'b0;
      AUX_CLOCK.src_primary <= 1'b0;
      AUX_CLOCK.mult <= rsc_pkg::RSC_AUX_MULT_FACTOR; // RULE_13
    end else begin
      AUX_CLOCK.mult <= rsc_pkg::RSC_AUX_MULT_FACTOR; // RULE_13
      if (aux_wr) begin
        AUX_CLOCK.enable <= WDATA[rsc_pkg::RSC_AUX_EN_BIT];
        AUX_CLOCK.src_primary <= WDATA[rsc_pkg::RSC_AUX_SRC_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [15:0] rd_word;

  always_comb begin
    rd_word = rsc_pkg::RSC_READ_ZERO;
    if (reg_hit(ADDR, rsc_pkg::RSC_CAUSE_IDX)) begin
      rd_word[7:0] = cause_reg;
    end else if (reg_hit(ADDR, rsc_pkg::RSC_OSC_CTRL_IDX)) begin
      rd_word[rsc_pkg::RSC_NEW_OSC_FIELD_MSB:rsc_pkg::RSC_NEW_OSC_FIELD_LSB] = new_osc_field_reg;
      rd_word[rsc_pkg::RSC_PTYPE_MSB:rsc_pkg::RSC_PTYPE_LSB] = ptype_reg;
    end else if (reg_hit(ADDR, rsc_pkg::RSC_AUX_CTRL_IDX)) begin
      rd_word[rsc_pkg::RSC_AUX_EN_BIT] = AUX_CLOCK.enable;
      rd_word[rsc_pkg::RSC_AUX_SRC_BIT] = AUX_CLOCK.src_primary;
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= rsc_pkg::RSC_READ_ZERO;
    end else if (RD) begin
      RDATA <= rd_word;
    end else begin
      RDATA <= rsc_pkg::RSC_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [7:0] cause_only_mask;
  assign cause_only_mask = 8'h01 << rsc_pkg::RSC_CAUSE_WDT_BIT;

  sequence s_src_drop;
    any_src ##1 !any_src [*2];
  endsequence

  sequence s_quiet_write;
    cause_wr && !any_src && !master_rst ##1 !any_src;
  endsequence

  property p_any_src_resets;
    @(posedge CLK) disable iff (RST)
    (|src_vec) |-> MASTER_SYSTEM_RESET;
  endproperty
  a_any_src_resets: assert property (p_any_src_resets) // RULE_01
    else $error("source active but master reset low");

  property p_sync_release;
    @(posedge CLK) disable iff (RST)
    s_src_drop |=> !MASTER_SYSTEM_RESET;
  endproperty
  a_sync_release: assert property (p_sync_release) // RULE_14
    else $error("master reset not released two edges after sources");

  property p_hold_after_drop;
    @(posedge CLK) disable iff (RST)
    any_src ##1 !any_src |-> MASTER_SYSTEM_RESET;
  endproperty
  a_hold_after_drop: assert property (p_hold_after_drop) // RULE_14
    else $error("master reset released too early");

  property p_por_flags;
    @(posedge CLK) disable iff (RST)
    RESET_SOURCES.power_on && (src_vec[7:2] == 6'h00) |=>
      cause_reg == rsc_pkg::RSC_CAUSE_POR_VALUE;
  endproperty
  a_por_flags: assert property (p_por_flags) // RULE_05
    else $error("power-on did not leave only bits one and zero");

  property p_wdt_flag;
    @(posedge CLK) disable iff (RST)
    RESET_SOURCES.wdt_timeout && !RESET_SOURCES.power_on |=>
      ((cause_reg & cause_only_mask) == cause_only_mask);
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) // RULE_04
    else $error("watchdog reset did not set its flag");

  property p_sw_write;
    @(posedge CLK) disable iff (RST)
    cause_wr && !(|src_vec) |=> cause_reg == $past(WDATA[7:0]);
  endproperty
  a_sw_write: assert property (p_sw_write) // RULE_06
    else $error("software write to cause flags not stored");

  property p_write_no_reset;
    @(posedge CLK) disable iff (RST)
    s_quiet_write |-> !MASTER_SYSTEM_RESET;
  endproperty
  a_write_no_reset: assert property (p_write_no_reset) // RULE_07
    else $error("cause write produced a reset");

  property p_new_osc_field_load;
    @(posedge CLK) disable iff (RST)
    master_rst |=> new_osc_field_reg == $past(OSC_SELECT_CONFIG_WORD[
      rsc_pkg::RSC_CFG_SEL_MSB:rsc_pkg::RSC_CFG_SEL_LSB]);
  endproperty
  a_new_osc_field_load: assert property (p_new_osc_field_load) // RULE_09
    else $error("new oscillator field not loaded on reset");

  property p_erased_start;
    @(posedge CLK) disable iff (RST)
    master_rst && OSC_SELECT_CONFIG_WORD == rsc_pkg::RSC_CFG_ERASED
      |=> ##1 OSC_MODE.div_n && !OSC_MODE.pll_en && !OSC_MODE.is_primary;
  endproperty
  a_erased_start: assert property (p_erased_start) // RULE_12
    else $error("erased device not in internal RC divide-N");

  property p_pll_decode;
    @(posedge CLK) disable iff (RST)
    1'b1 |=> OSC_MODE.pll_en ==
      ($past(new_osc_field_reg) == rsc_pkg::RSC_OSC_PRIMARY_PLL ||
       $past(new_osc_field_reg) == rsc_pkg::RSC_OSC_INTERNAL_RC_DIV_N_PLL);
  endproperty
  a_pll_decode: assert property (p_pll_decode) // RULE_10
    else $error("pll enable decode wrong");

  property p_ptype_ignored;
    @(posedge CLK) disable iff (RST)
    !OSC_MODE.is_primary |-> OSC_MODE.prim_type == 2'h0;
  endproperty
  a_ptype_ignored: assert property (p_ptype_ignored) // RULE_11
    else $error("primary type shown for internal source");

  property p_aux_mult;
    @(posedge CLK) disable iff (RST)
    $rose(AUX_CLOCK.enable) |-> AUX_CLOCK.mult == rsc_pkg::RSC_AUX_MULT_FACTOR;
  endproperty
  a_aux_mult: assert property (p_aux_mult) // RULE_13
    else $error("aux multiplier not sixteen");

endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------
  // stimulus and design
  // ------------------------------------------------------------
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] cfg = 8'hFF;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic fire = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [15:0] RDATA;
  logic MASTER_SYSTEM_RESET;
  rsc_pkg::rsc_src_type src;
  rsc_pkg::rsc_osc_mode_type OSC_MODE;
  rsc_pkg::rsc_aux_type AUX_CLOCK;
  int n_mismatch = 0;
  int n_checks = 0;

  always #10 CLK = ~CLK;

  rsc_src_model far (.fire(fire), .idx(idx), .src(src));

  rsc_top uut (
    .CLK(CLK), .RST(RST), .RESET_SOURCES(src),
    .OSC_SELECT_CONFIG_WORD(cfg), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA),
    .MASTER_SYSTEM_RESET(MASTER_SYSTEM_RESET),
    .OSC_MODE(OSC_MODE), .AUX_CLOCK(AUX_CLOCK)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // bounded wait for the combined reset to drop
  task automatic wait_low();
    int j;
    for (j = 0; j < 8; j++) begin
      if (MASTER_SYSTEM_RESET === 1'b0) break;
      @(posedge CLK);
      #1;
    end
    if (MASTER_SYSTEM_RESET !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic pulse(input logic [3:0] k);
    @(posedge CLK);
    fire <= 1'b1;
    idx <= k;
    #1;
    chk(16'(MASTER_SYSTEM_RESET), 16'h0001);
    @(posedge CLK);
    fire <= 1'b0;
    @(posedge CLK);
    #1;
    chk(16'(MASTER_SYSTEM_RESET), 16'h0001);
    wait_low();
  endtask

  // expected decode of select and primary type
  function automatic logic [7:0] exp_mode(input logic [2:0] s,
                                          input logic [1:0] p);
    logic [7:0] m;
    logic prim;
    prim = (s == 3'h2) || (s == 3'h3);
    m = 8'h00;
    m[7] = (s != 3'h4);
    m[6] = prim;
    m[5] = (s == 3'h3) || (s == 3'h1);
    m[4] = (s == 3'h7) || (s == 3'h1);
    m[3] = (s == 3'h6);
    m[2] = (s == 3'h5);
    m[1:0] = prim ? p : 2'h0;
    return m;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [7:0] v;
    logic [7:0] ec;
    logic [2:0] sel;
    logic [1:0] pt;
    logic [3:0] k;
    int i;
    void'($urandom(54968));
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    #1;
    wait_low();
    rd(rsc_pkg::RSC_CAUSE_IDX, d);
    chk(d, 16'h0003);
    rd(rsc_pkg::RSC_OSC_CTRL_IDX, d);
    chk(d, 16'h0703);
    chk({8'h00, OSC_MODE}, {8'h00, exp_mode(3'h7, 2'h3)});
    chk({9'h000, AUX_CLOCK}, 16'h0010);
    wr(rsc_pkg::RSC_AUX_CTRL_IDX, 16'h0003);
    repeat (2) @(posedge CLK);
    #1;
    chk({9'h000, AUX_CLOCK}, 16'h0070);
    wr(rsc_pkg::RSC_AUX_CTRL_IDX, 16'h0001);
    repeat (2) @(posedge CLK);
    #1;
    chk({9'h000, AUX_CLOCK}, 16'h0030);
    rd(4'hF, d);
    chk(d, 16'h0000);
    // flag writes are status only, no reset may follow
    wr(rsc_pkg::RSC_CAUSE_IDX, 16'h00FF);
    repeat (4) begin
      @(posedge CLK);
      #1;
      chk(16'(MASTER_SYSTEM_RESET), 16'h0000);
    end
    rd(rsc_pkg::RSC_CAUSE_IDX, d);
    chk(d, 16'h00FF);
    // read data must not linger past its one cycle
    @(posedge CLK);
    #1;
    chk(RDATA, 16'h0000);
    // every select code and every source, then random ones
    for (i = 0; i < 24; i++) begin
      sel = i[2:0];
      pt = 2'($urandom % 3);
      k = (i < 10) ? 4'(i) : 4'($urandom % 10);
      v = 8'($urandom);
      @(posedge CLK);
      cfg <= {3'h0, pt, sel};
      wr(rsc_pkg::RSC_CAUSE_IDX, {8'h00, v});
      wr(rsc_pkg::RSC_OSC_CTRL_IDX, {5'h00, ~sel, 8'h00});
      pulse(k);
      ec = (k == 4'h0) ? 8'h03 : (v | (8'h01 << ((k > 4'h7) ? 7 : k)));
      rd(rsc_pkg::RSC_CAUSE_IDX, d);
      chk(d, {8'h00, ec});
      wr(rsc_pkg::RSC_CAUSE_IDX, 16'h0000);
      rd(rsc_pkg::RSC_OSC_CTRL_IDX, d);
      chk(d, {5'h00, sel, 6'h00, pt});
      chk({8'h00, OSC_MODE}, {8'h00, exp_mode(sel, pt)});
      chk({9'h000, AUX_CLOCK}, 16'h0010);
    end
    print_verdict();
  end
endmodule
